// [design/standby_clock_pkg.sv]
// constants for the clock timing and standby controller
package standby_clock_pkg;

    // =====================================================================
    // register map (printed offsets are not word aligned, so they are indices)
    localparam logic [7:0] STOP_MODE_CONTROL_IDX       = 8'h38;
    localparam logic [7:0] OSCILLATOR_IDLE_CONTROL_IDX = 8'h39;
    localparam logic [7:0] DIVIDER_CONTROL_IDX         = 8'h3a;
    localparam logic [7:0] STATUS_IDX                  = 8'h3b;
    localparam logic [9:0] ADDR_STOP_MODE_CONTROL       = {STOP_MODE_CONTROL_IDX, 2'b00};
    localparam logic [9:0] ADDR_OSCILLATOR_IDLE_CONTROL = {OSCILLATOR_IDLE_CONTROL_IDX, 2'b00};
    localparam logic [9:0] ADDR_DIVIDER_CONTROL         = {DIVIDER_CONTROL_IDX, 2'b00};
    localparam logic [9:0] ADDR_STATUS                  = {STATUS_IDX, 2'b00};

    // =====================================================================
    // stop_mode_control fields
    localparam int STOP_BIT    = 7;
    localparam int RELEASE_METHOD_SEL_BIT    = 6;
    localparam int RETURN_MODE_SEL_BIT    = 5;
    localparam int PORT_HOLD_IN_HALT_BIT   = 4;
    localparam int WUT_LSB     = 2;
    // oscillator_idle_control fields
    localparam int XEN_BIT     = 7;
    localparam int SYS_CLOCK_SEL_BIT   = 5;
    localparam int IDLE_BIT    = 4;
    // divider_control_reg fields
    localparam int DIVIDER_INPUT_SEL_BIT   = 4;

    // =====================================================================
    // reset values and read masks
    localparam logic [7:0] SMC_RESET      = 8'h00;
    localparam logic [7:0] OIC_RESET      = 8'h80;
    localparam logic [7:0] DIV_RESET      = 8'h00;
    localparam logic [7:0] INDET_VALUE    = 8'h00;
    localparam logic [7:0] SMC_READ_MASK  = 8'hfc;
    localparam logic [7:0] OIC_READ_MASK  = 8'hf0;
    localparam logic [7:0] DIV_READ_MASK  = 8'he7;

    // =====================================================================
    // counter geometry
    localparam int PRESCALE_STAGES = 3;
    localparam int DIVIDER_STAGES  = 21;
    localparam int STATES_PER_MC   = 4;
    localparam logic [1:0] WUT_3X16 = 2'b00;
    localparam logic [1:0] WUT_16   = 2'b01;
    localparam logic [1:0] WUT_14   = 2'b10;
    localparam int WUT_EXP_16       = 16;
    localparam int WUT_EXP_14       = 14;

    // =====================================================================
    // operating modes
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_IDLE   = 2'b01,
        MODE_STOP   = 2'b11,
        MODE_WARMUP = 2'b10
    } mode_type;

endpackage

// [design/standby_clock_timing_control.sv]
// clock timing generator and standby mode controller with apb registers
//
// Notes on behaviour
// R01 - three stage prescaler, 21 stage divider and machine cycle counter on fc
// R02 - prescaler and divider clear on reset, stop entry and stop exit
// R03 - divider control bits 4 and 3 read as indeterminate (zero)
// R04 - machine cycle is four states s0 to s3, one clock each
// R05 - single clock: machine cycle is four fc periods
// R06 - after reset the block is in normal mode
// R07 - idle halts cpu and watchdog, peripherals keep running
// R08 - interrupt ends idle; master enable picks service or resume
// R09 - stop halts oscillator and all internal operation, state kept
// R10 - writing 1 to stop bit enters stop mode
// R11 - release method: 0 rising edge, 1 high level of stop pin
// R12 - software sets return mode 0 before stop; 1 reserved
// R13 - port hold bit: 0 tristates ports in stop, 1 holds them
// R14 - warm-up field selects 3x2^16, 2^16, 2^14 fc; doubled with divide option
// R15 - pin release counts warm-up then resumes after stop instruction
// R16 - reset ends stop and always comes up in normal mode
// R17 - stop control bits 1 and 0 read indeterminate (zero)
// R18 - stop bit cleared by hardware on release from stop
// R19 - clearing oscillator enable resets the device
// R20 - clock select reads active clock; 0 high frequency, 1 reserved
// R21 - writing 1 to idle bit enters idle mode
// R22 - stop exit rewrites oscillator enable to 1 and clock select to 0
// R23 - software writes 0 to bit 6; bits 3 to 0 read indeterminate
// R24 - level mode stop request with pin high goes straight to warm-up
`timescale 1ns/1ps

module standby_clock_timing_control
    import standby_clock_pkg::*;
#(
    parameter int PRESCALE_W = PRESCALE_STAGES,
    parameter int DIVIDER_W  = DIVIDER_STAGES
) (
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [9:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // stop pin and interrupt side
    input  wire logic        STOP_PIN,
    input  wire logic        IRQ_REQ,
    input  wire logic        MASTER_IRQ_ENABLE,
    // mode and clock outputs
    output logic             CPU_RUN,
    output logic             WATCHDOG_RUN,
    output logic             PERIPH_RUN,
    output logic             OSC_RUN,
    output logic             PORT_TRISTATE,
    output logic             IRQ_SERVICE,
    output logic             SELF_RESET,
    output logic [1:0]       MC_STATE,
    output logic             MC_END,
    output logic             DIVIDER_PULSE_OUT,
    output logic [DIVIDER_W-1:0] DIVIDER_TAPS
);

    // =====================================================================
    // elaboration checks
    // the status word packs mode and divider into 32 bits, so the chain is capped
    if (PRESCALE_W < 1 || DIVIDER_W < WUT_EXP_16 + 3 || DIVIDER_W > 30) begin : g_bad_width
        $error("divider chain width not supported");
    end

    // =====================================================================
    // state
    typedef struct packed {
        logic                  stop_req;
        logic                  release_method_sel;
        logic                  return_mode_sel;
        logic                  port_hold_in_halt;
        logic [1:0]            warmup_time_sel;
        logic                  hf_osc_enable;
        logic                  sys_clock_sel;
        logic                  idle_req;
        logic                  divider_input_sel;
        logic [7:0]            div_other;
        mode_type              mode;
        logic [PRESCALE_W-1:0] pre;
        logic [DIVIDER_W-1:0]  div;
        logic [1:0]            mc;
        logic [DIVIDER_W+1:0]  wu_cnt;
        logic                  pin_s1;
        logic                  pin_s2;
        logic                  pin_prev;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
        logic                  irq_service;
        logic                  self_reset;
        logic                  divider_pulse_out;
        logic                  cpu_run;
        logic                  wdt_run;
        logic                  periph_run;
        logic                  osc_run;
        logic                  port_tri;
        logic                  mc_end;
    } state_type;

    state_type cur_ff;
    state_type nxt_ff;

    logic                 wr_en;
    logic [7:0]           wbyte;
    logic                 release_pin;
    logic [DIVIDER_W+1:0] wu_target;
    logic                 running;
    logic [31:0]          rd_word;
    logic                 addr_bad;

    assign wr_en = PSEL && PENABLE && PWRITE;
    assign wbyte = PWDATA[7:0];

    // =====================================================================
    // warm-up target
    always_comb begin
        wu_target = '0;
        // R14 warm-up count select
        unique case (cur_ff.warmup_time_sel)
            WUT_3X16: wu_target = ({{(DIVIDER_W+1){1'b0}}, 1'b1} << WUT_EXP_16)
                                + ({{(DIVIDER_W+1){1'b0}}, 1'b1} << (WUT_EXP_16 + 1));
            WUT_16:   wu_target = {{(DIVIDER_W+1){1'b0}}, 1'b1} << WUT_EXP_16;
            WUT_14:   wu_target = {{(DIVIDER_W+1){1'b0}}, 1'b1} << WUT_EXP_14;
            default:  wu_target = {{(DIVIDER_W+1){1'b0}}, 1'b1} << WUT_EXP_14;
        endcase
        if (cur_ff.divider_input_sel)
            wu_target = wu_target << 1;
    end

    // R11 release condition
    assign release_pin = cur_ff.release_method_sel ? cur_ff.pin_s2 : (cur_ff.pin_s2 && !cur_ff.pin_prev);
    // R09 prescaler, divider and machine cycle hold while halted or warming up
    assign running = (cur_ff.mode == MODE_NORMAL) || (cur_ff.mode == MODE_IDLE);

    // =====================================================================
    // read decode, sampled in the setup cycle so data and error stand with ready
    always_comb begin
        rd_word  = '0;
        addr_bad = 1'b0;
        unique case (PADDR)
            // R17 low bits of stop control read as zero
            ADDR_STOP_MODE_CONTROL:
                rd_word[7:0] = {cur_ff.stop_req, cur_ff.release_method_sel, cur_ff.return_mode_sel,
                                cur_ff.port_hold_in_halt, cur_ff.warmup_time_sel, 2'b00} & SMC_READ_MASK;
            // R23 bits 3 to 0 read as zero
            ADDR_OSCILLATOR_IDLE_CONTROL:
                rd_word[7:0] = {cur_ff.hf_osc_enable, 1'b0, cur_ff.sys_clock_sel, cur_ff.idle_req,
                                4'h0} & OIC_READ_MASK;
            // R03 bits 4 and 3 read as zero
            ADDR_DIVIDER_CONTROL:
                rd_word[7:0] = cur_ff.div_other & DIV_READ_MASK;
            ADDR_STATUS:
                rd_word = {{(30-DIVIDER_W){1'b0}}, cur_ff.mode, cur_ff.div};
            default: begin
                rd_word  = {24'h000000, INDET_VALUE};
                addr_bad = 1'b1;
            end
        endcase
    end

    // =====================================================================
    // next state
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.pin_s1   = STOP_PIN;
        nxt_ff.pin_s2   = cur_ff.pin_s1;
        nxt_ff.pin_prev = cur_ff.pin_s2;
        nxt_ff.pready   = PSEL && !PENABLE;
        nxt_ff.pslverr  = 1'b0;
        nxt_ff.irq_service = 1'b0;
        nxt_ff.self_reset  = 1'b0;

        // R01 prescaler, divider and machine cycle counter
        // R04 four states per machine cycle
        // R05 one state per fc period
        if (running) begin
            nxt_ff.pre = cur_ff.pre + 1'b1;
            if (&cur_ff.pre)
                nxt_ff.div = cur_ff.div + 1'b1;
            nxt_ff.mc = cur_ff.mc + 2'b01;
        end
        nxt_ff.divider_pulse_out = running && (&cur_ff.pre) && (&cur_ff.div);

        // register writes
        if (wr_en && cur_ff.pready) begin
            unique case (PADDR)
                ADDR_STOP_MODE_CONTROL: begin
                    nxt_ff.release_method_sel     = wbyte[RELEASE_METHOD_SEL_BIT];
                    // R12 return mode kept as written; only 0 is meaningful
                    nxt_ff.return_mode_sel     = wbyte[RETURN_MODE_SEL_BIT];
                    nxt_ff.port_hold_in_halt    = wbyte[PORT_HOLD_IN_HALT_BIT];
                    nxt_ff.warmup_time_sel      = wbyte[WUT_LSB +: 2];
                    // R10 stop request
                    nxt_ff.stop_req = wbyte[STOP_BIT];
                end
                ADDR_OSCILLATOR_IDLE_CONTROL: begin
                    nxt_ff.hf_osc_enable      = wbyte[XEN_BIT];
                    // R20 only high-frequency clock is supported
                    nxt_ff.sys_clock_sel    = 1'b0;
                    // R21 idle request
                    nxt_ff.idle_req = wbyte[IDLE_BIT];
                end
                ADDR_DIVIDER_CONTROL: begin
                    nxt_ff.divider_input_sel     = wbyte[DIVIDER_INPUT_SEL_BIT];
                    nxt_ff.div_other = wbyte & DIV_READ_MASK;
                end
                ADDR_STATUS: begin
                end
                default: begin
                end
            endcase
        end

        // register reads and the error flag, taken in the setup cycle
        if (PSEL && !PENABLE) begin
            nxt_ff.pslverr = addr_bad;
            if (!PWRITE)
                nxt_ff.prdata = rd_word;
        end

        // R19 oscillator enable cleared requests a device reset
        if (!cur_ff.hf_osc_enable) begin
            nxt_ff.self_reset = 1'b1;
            nxt_ff.hf_osc_enable        = 1'b1;
        end

        // =================================================================
        // mode sequencing
        unique case (cur_ff.mode)
            MODE_NORMAL: begin
                if (cur_ff.stop_req) begin
                    // R24 level mode with pin high skips stop
                    if (cur_ff.release_method_sel && cur_ff.pin_s2) begin
                        nxt_ff.mode = MODE_WARMUP;
                    end else begin
                        nxt_ff.mode = MODE_STOP;
                    end
                    // R02 clear on stop entry
                    nxt_ff.pre    = '0;
                    nxt_ff.div    = '0;
                    nxt_ff.mc     = '0;
                    nxt_ff.wu_cnt = '0;
                end else if (cur_ff.idle_req) begin
                    // R07 idle entry
                    nxt_ff.mode = MODE_IDLE;
                end
            end
            MODE_IDLE: begin
                // R08 interrupt ends idle
                if (IRQ_REQ) begin
                    nxt_ff.mode        = MODE_NORMAL;
                    nxt_ff.idle_req    = 1'b0;
                    nxt_ff.irq_service = MASTER_IRQ_ENABLE;
                end
            end
            MODE_STOP: begin
                // R11 stop pin release
                if (release_pin) begin
                    nxt_ff.mode   = MODE_WARMUP;
                    nxt_ff.wu_cnt = '0;
                end
            end
            MODE_WARMUP: begin
                // R15 count warm-up then resume
                nxt_ff.wu_cnt = cur_ff.wu_cnt + 1'b1;
                if (cur_ff.wu_cnt + 1'b1 >= wu_target) begin
                    nxt_ff.mode     = MODE_NORMAL;
                    // R18 stop bit self clears
                    nxt_ff.stop_req = 1'b0;
                    // R22 oscillator enable and clock select rewrite
                    nxt_ff.hf_osc_enable      = 1'b1;
                    nxt_ff.sys_clock_sel    = 1'b0;
                    // R02 clear on stop exit
                    nxt_ff.pre      = '0;
                    nxt_ff.div      = '0;
                    nxt_ff.mc       = '0;
                end
            end
            default: nxt_ff.mode = MODE_NORMAL;
        endcase

        // outputs follow the next mode so they switch on the same edge
        // R07 cpu and watchdog stop in idle
        nxt_ff.cpu_run    = (nxt_ff.mode == MODE_NORMAL);
        nxt_ff.wdt_run    = (nxt_ff.mode == MODE_NORMAL);
        // R09 everything stops in stop
        nxt_ff.periph_run = (nxt_ff.mode == MODE_NORMAL) || (nxt_ff.mode == MODE_IDLE);
        nxt_ff.osc_run    = (nxt_ff.mode != MODE_STOP);
        // R13 port hold select in stop
        nxt_ff.port_tri   = (nxt_ff.mode == MODE_STOP) && !nxt_ff.port_hold_in_halt;
        // R04 last state of the machine cycle
        nxt_ff.mc_end     = nxt_ff.periph_run && (&nxt_ff.mc);
    end

    // =====================================================================
    // registers
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            // R06 normal after reset
            // R16 reset also ends stop into normal
            cur_ff           <= '0;
            cur_ff.mode      <= MODE_NORMAL;
            {cur_ff.stop_req, cur_ff.release_method_sel, cur_ff.return_mode_sel, cur_ff.port_hold_in_halt, cur_ff.warmup_time_sel} <= SMC_RESET[7:2];
            cur_ff.hf_osc_enable       <= OIC_RESET[XEN_BIT];
            cur_ff.divider_input_sel     <= DIV_RESET[DIVIDER_INPUT_SEL_BIT];
            cur_ff.cpu_run    <= 1'b1;
            cur_ff.wdt_run    <= 1'b1;
            cur_ff.periph_run <= 1'b1;
            cur_ff.osc_run    <= 1'b1;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // =====================================================================
    // outputs, all from flip-flops
    assign PRDATA            = cur_ff.prdata;
    assign PREADY            = cur_ff.pready;
    assign PSLVERR           = cur_ff.pslverr;
    // R07 cpu and watchdog stop in idle; R09 everything stops in stop
    assign CPU_RUN           = cur_ff.cpu_run;
    assign WATCHDOG_RUN      = cur_ff.wdt_run;
    assign PERIPH_RUN        = cur_ff.periph_run;
    assign OSC_RUN           = cur_ff.osc_run;
    // R13 port hold select in stop
    assign PORT_TRISTATE     = cur_ff.port_tri;
    assign IRQ_SERVICE       = cur_ff.irq_service;
    assign SELF_RESET        = cur_ff.self_reset;
    assign MC_STATE          = cur_ff.mc;
    assign MC_END            = cur_ff.mc_end;
    assign DIVIDER_PULSE_OUT = cur_ff.divider_pulse_out;
    assign DIVIDER_TAPS      = cur_ff.div;

endmodule // standby_clock_timing_control

// [test/standby_clock_properties.sv]
// assertion checker for the clock timing and standby controller
`timescale 1ns/1ps
module standby_clock_properties
    import standby_clock_pkg::*;
#(
    parameter int DIVIDER_W = DIVIDER_STAGES
) (
    // clock, reset and apb answer
    input wire logic                 CLK_SYS,
    input wire logic                 RST_B,
    input wire logic                 PSEL,
    input wire logic                 PENABLE,
    input wire logic                 PREADY,
    input wire logic                 PSLVERR,
    // interrupt side
    input wire logic                 IRQ_REQ,
    input wire logic                 MASTER_IRQ_ENABLE,
    // mode and timing outputs
    input wire logic                 CPU_RUN,
    input wire logic                 WATCHDOG_RUN,
    input wire logic                 PERIPH_RUN,
    input wire logic                 OSC_RUN,
    input wire logic                 PORT_TRISTATE,
    input wire logic                 IRQ_SERVICE,
    input wire logic                 SELF_RESET,
    input wire logic [1:0]           MC_STATE,
    input wire logic                 MC_END,
    input wire logic                 DIVIDER_PULSE_OUT,
    input wire logic [DIVIDER_W-1:0] DIVIDER_TAPS
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // ==========================================
    // timing generator and modes
    a_mc_step: assert property (
        CPU_RUN && $past(CPU_RUN) && $past(RST_B) |-> MC_STATE == 2'($past(MC_STATE) + 2'd1))
        else $error("machine state skipped");
    a_div_steady: assert property (
        PERIPH_RUN && $past(PERIPH_RUN) && MC_STATE != 2'd0 |-> $stable(DIVIDER_TAPS)) else $error("divider stepped early");
    a_dvo_quiet: assert property (DIVIDER_TAPS != '0 |-> !DIVIDER_PULSE_OUT) else $error("divider pulse off wrap");
    a_mc_end_state: assert property (MC_END |-> MC_STATE == 2'd3) else $error("cycle end outside s3");
    a_stop_halts: assert property (
        !OSC_RUN |-> !CPU_RUN && !PERIPH_RUN && !WATCHDOG_RUN && DIVIDER_TAPS == '0) else $error("stop not halted");
    a_idle_units: assert property (
        PERIPH_RUN && !CPU_RUN |-> !WATCHDOG_RUN && OSC_RUN) else $error("idle units wrong");
    a_idle_wake: assert property (
        PERIPH_RUN && !CPU_RUN && IRQ_REQ |=> CPU_RUN && IRQ_SERVICE == $past(MASTER_IRQ_ENABLE))
        else $error("idle wake wrong");
    a_reset_normal: assert property (!$past(RST_B) |-> CPU_RUN) else $error("not normal after reset");
    a_port_float: assert property (PORT_TRISTATE |-> !OSC_RUN) else $error("ports float outside stop");
    a_self_reset_pulse: assert property (SELF_RESET |=> !SELF_RESET) else $error("self reset stuck");
    // ==========================================
    // register bus answer
    a_pready_wait: assert property (PSEL && !PENABLE |=> PREADY) else $error("ready timing");
    a_pready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
    a_slverr_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
    c_service: cover property (IRQ_SERVICE);
    c_stop: cover property ($fell(OSC_RUN));
    c_self_reset: cover property (SELF_RESET);
    c_slverr: cover property (PSLVERR);
endmodule // standby_clock_properties

bind standby_clock_timing_control standby_clock_properties #(.DIVIDER_W(DIVIDER_W)) i_standby_clock_properties (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .IRQ_REQ(IRQ_REQ), .MASTER_IRQ_ENABLE(MASTER_IRQ_ENABLE), .CPU_RUN(CPU_RUN), .WATCHDOG_RUN(WATCHDOG_RUN),
    .PERIPH_RUN(PERIPH_RUN), .OSC_RUN(OSC_RUN), .PORT_TRISTATE(PORT_TRISTATE), .IRQ_SERVICE(IRQ_SERVICE),
    .SELF_RESET(SELF_RESET), .MC_STATE(MC_STATE), .MC_END(MC_END), .DIVIDER_PULSE_OUT(DIVIDER_PULSE_OUT),
    .DIVIDER_TAPS(DIVIDER_TAPS));

// [test/stop_irq_partner.sv]
// model of the stop pin source and the cpu interrupt logic
`timescale 1ns/1ps
module stop_irq_partner (
    // clock and observed state
    input  wire logic clk_sys,
    input  wire logic cpu_run,
    input  wire logic irq_service,
    // driven towards the block
    output logic      stop_pin,
    output logic      irq_req,
    output logic      master_irq_enable
);
    initial begin
        stop_pin = 1'b0;
        irq_req = 1'b0;
        master_irq_enable = 1'b0;
    end
    task automatic drive_pin(input logic lvl);
        @(posedge clk_sys);
        stop_pin <= lvl;
    endtask
    task automatic request_irq(input logic en, output logic serviced);
        int n;
        serviced = 1'b0;
        n = 0;
        @(posedge clk_sys);
        master_irq_enable <= en;
        irq_req <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (irq_service === 1'b1) serviced = 1'b1;
        end while (cpu_run !== 1'b1 && n < 50);
        irq_req <= 1'b0;
    endtask
endmodule // stop_irq_partner

// [test/standby_clock_timing_control_tb.sv]
// self-checking bench for the clock timing and standby controller
`timescale 1ns/1ps
module standby_clock_timing_control_tb;
    import standby_clock_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_b   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [9:0]  paddr   = 10'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, got, stop_pin, irq_req, irq_en;
    logic        cpu_run, wdt_run, periph_run, osc_run, port_tri, irq_service, self_reset, mc_end;
    logic [1:0]  mc_state;
    logic [20:0] div_taps;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          n_selfrst  = 0;
    int          n;

    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (self_reset === 1'b1) n_selfrst++;

    standby_clock_timing_control i_standby_clock_timing_control (
        .CLK_SYS(clk_sys), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .STOP_PIN(stop_pin),
        .IRQ_REQ(irq_req), .MASTER_IRQ_ENABLE(irq_en), .CPU_RUN(cpu_run), .WATCHDOG_RUN(wdt_run),
        .PERIPH_RUN(periph_run), .OSC_RUN(osc_run), .PORT_TRISTATE(port_tri), .IRQ_SERVICE(irq_service),
        .SELF_RESET(self_reset), .MC_STATE(mc_state), .MC_END(mc_end), .DIVIDER_PULSE_OUT(),
        .DIVIDER_TAPS(div_taps));
    stop_irq_partner i_stop_irq_partner (.clk_sys(clk_sys), .cpu_run(cpu_run), .irq_service(irq_service),
        .stop_pin(stop_pin), .irq_req(irq_req), .master_irq_enable(irq_en));

    // ==========================================
    // shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        if (k >= 20) n_mismatch++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask
    // in the edge run counting starts at the pin edge, so the two sync flops add a little
    task automatic wait_run;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (cpu_run !== 1'b1 && n < 40000);
    endtask

    // ==========================================
    // scenarios
    task automatic t_regs;
        rd_chk(ADDR_STOP_MODE_CONTROL, 32'h00, "smc reset");
        rd_chk(ADDR_OSCILLATOR_IDLE_CONTROL, 32'h80, "oic reset");
        apb(1'b1, ADDR_STOP_MODE_CONTROL, 32'h1b);
        rd_chk(ADDR_STOP_MODE_CONTROL, 32'h18, "smc low bits");
        apb(1'b1, ADDR_OSCILLATOR_IDLE_CONTROL, 32'h8f);
        rd_chk(ADDR_OSCILLATOR_IDLE_CONTROL, 32'h80, "oic low bits");
        // divide option stays set for the edge stop run
        apb(1'b1, ADDR_DIVIDER_CONTROL, 32'h18);
        rd_chk(ADDR_DIVIDER_CONTROL, 32'h00, "div bits");
        rd_chk(10'h000, 32'h0, "unmapped data");
        check("unmapped err", 32'(err), 32'h1);
    endtask
    task automatic t_idle;
        apb(1'b1, ADDR_OSCILLATOR_IDLE_CONTROL, 32'h90);
        repeat (3) @(posedge clk_sys);
        check("idle units", 32'({periph_run, wdt_run, cpu_run, osc_run}), 32'h9);
        i_stop_irq_partner.request_irq(1'b1, got);
        check("idle serviced", 32'({got, cpu_run}), 32'h3);
        apb(1'b1, ADDR_OSCILLATOR_IDLE_CONTROL, 32'h90);
        repeat (3) @(posedge clk_sys);
        i_stop_irq_partner.request_irq(1'b0, got);
        check("idle resumed", 32'({got, cpu_run}), 32'h1);
        rd_chk(ADDR_OSCILLATOR_IDLE_CONTROL, 32'h80, "idle bit");
    endtask
    task automatic t_stop_edge;
        i_stop_irq_partner.drive_pin(1'b1);
        apb(1'b1, ADDR_STOP_MODE_CONTROL, 32'h88);
        repeat (3) @(posedge clk_sys);
        check("stop entry", 32'({osc_run, cpu_run, port_tri}), 32'h1);
        i_stop_irq_partner.drive_pin(1'b0);
        repeat (4) @(posedge clk_sys);
        check("falling edge", 32'(osc_run), 32'h0);
        i_stop_irq_partner.drive_pin(1'b1);
        wait_run;
        check("warmup doubled", 32'(n >= 32768 && n <= 32776), 32'h1);
        rd_chk(ADDR_STOP_MODE_CONTROL, 32'h08, "stop cleared");
        rd_chk(ADDR_OSCILLATOR_IDLE_CONTROL, 32'h80, "osc rewritten");
    endtask
    task automatic t_stop_level;
        apb(1'b1, ADDR_DIVIDER_CONTROL, 32'h00);
        apb(1'b1, ADDR_STOP_MODE_CONTROL, 32'hc8);
        repeat (3) @(posedge clk_sys);
        check("level pin high", 32'({osc_run, cpu_run}), 32'h2);
        rd_chk(ADDR_STATUS, 32'h0040_0000, "status in warm-up");
        wait_run;
        check("warmup plain", 32'(n >= 16374 && n <= 16386), 32'h1);
    endtask
    task automatic t_reset_stop;
        apb(1'b1, ADDR_STOP_MODE_CONTROL, 32'h98);
        repeat (3) @(posedge clk_sys);
        check("held ports", 32'({osc_run, port_tri}), 32'h0);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check("reset wake", 32'(cpu_run), 32'h1);
        rd_chk(ADDR_STOP_MODE_CONTROL, 32'h00, "smc after reset");
    endtask
    task automatic t_self_reset;
        apb(1'b1, ADDR_OSCILLATOR_IDLE_CONTROL, 32'h00);
        repeat (4) @(posedge clk_sys);
        check("self reset", 32'(n_selfrst), 32'h1);
        rd_chk(ADDR_OSCILLATOR_IDLE_CONTROL, 32'h80, "osc back");
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_regs;
        t_idle;
        t_stop_edge;
        t_stop_level;
        t_reset_stop;
        t_self_reset;
        tally_and_finish;
    end
    // two warm-ups dominate the run
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_mismatch++;
        tally_and_finish;
    end
endmodule // standby_clock_timing_control_tb
